// file: pkg/csos_pkg.sv
package csos_pkg;
  // ----------------------------------------
  // pin function select codes
  // ----------------------------------------
  localparam logic [3:0] SEL_LINE_DRV = 4'h0;
  localparam logic [3:0] SEL_RX_LAMP = 4'h1;
  localparam logic [3:0] SEL_TX_LAMP = 4'h2;
  localparam logic [3:0] SEL_SLEEP_N = 4'h3;
  localparam logic [3:0] SEL_BOTH_LAMP = 4'h4;
  localparam logic [3:0] SEL_POWER_EN_N = 4'h5;
  localparam logic [3:0] SEL_CHARGE = 4'h6;
  localparam logic [3:0] SEL_CHARGE_N = 4'h7;
  localparam logic [3:0] SEL_SLEEP = 4'h8;
  // ----------------------------------------
  // config memory layout
  // ----------------------------------------
  localparam logic [9:0] CFG_BASE = 10'h050;
  localparam logic [1:0] CFG_WORDS = 2'h3;
  localparam logic [15:0] DEF_PIN_SEL = 16'h3210;
  localparam logic [15:0] DEF_OPTIONS = 16'h0600;
  localparam logic [15:0] DEF_MAX_POWER = 16'h005a;
  localparam int INV_TXD = 0;
  localparam int INV_RXD = 1;
  localparam int INV_RTS = 2;
  localparam int INV_CTS = 3;
  localparam int INV_DTR = 4;
  localparam int INV_DSR = 5;
  localparam int INV_DCD = 6;
  localparam int INV_RI = 7;
  localparam int OPT_PULLDOWN = 8;
  localparam int OPT_WAKE = 9;
  localparam int OPT_SERIAL = 10;
  localparam int OPT_SELF_PWR = 11;
  localparam logic [15:0] USB_VERSION = 16'h0200;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_KHZ = 25000;
  localparam int LAMP_TIME_MS = 5;
  localparam int WAKE_TIME_MS = 20;
  localparam int LAMP_CYC = LAMP_TIME_MS * CLK_KHZ;
  localparam int WAKE_CYC = WAKE_TIME_MS * CLK_KHZ;
  typedef enum logic [1:0] {
    LD_IDLE = 2'b00,
    LD_READ = 2'b01,
    LD_DONE = 2'b10
  } csos_load_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_LEAD = 2'b01,
    TX_FRAME = 2'b10
  } csos_txen_t;
endpackage

// file: rtl/csos_top.sv
`timescale 1ns/1ps
module csos_top #(
  parameter int LAMP_CYC = csos_pkg::LAMP_CYC,
  parameter int WAKE_CYC = csos_pkg::WAKE_CYC,
  parameter int CW = 20
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_usb_reset,
  input wire logic i_suspended,
  input wire logic i_enumerated,
  input wire logic i_dcp_short,
  input wire logic i_uart_rx_byte,
  input wire logic i_usb_rx_byte,
  input wire logic i_tx_char_ready,
  input wire logic i_bit_tick,
  input wire logic i_tx_stop_bit,
  input wire logic i_txd,
  input wire logic i_rts,
  input wire logic i_dtr,
  input wire logic i_rxd_pin,
  input wire logic i_cts_pin,
  input wire logic i_dsr_pin,
  input wire logic i_carrier_detect_pin,
  input wire logic i_ring_indicate_n_pin,
  input wire logic i_cfg_rd_valid,
  input wire logic [15:0] i_cfg_rd_data,
  output logic o_cfg_rd_en,
  output logic [9:0] o_cfg_rd_addr,
  output logic o_cfg_loaded,
  output logic [3:0] o_status_pin_out,
  output logic [3:0] o_status_pin_oe_n,
  output logic o_line_driver_enable,
  output logic o_uart_tx_go,
  output logic o_uart_txd,
  output logic o_uart_rts,
  output logic o_uart_dtr,
  output logic o_uart_oe_n,
  output logic o_uart_pulldown,
  output logic o_rxd,
  output logic o_cts,
  output logic o_dsr,
  output logic o_carrier_detect,
  output logic o_ring_indicate,
  output logic o_suspend_request,
  output logic o_remote_wake,
  output logic [15:0] o_usb_version,
  output logic [8:0] o_max_power_ma,
  output logic o_bus_powered,
  output logic o_serial_enable
);
  initial begin
    if (LAMP_CYC < 1 || LAMP_CYC >= (1 << CW) || WAKE_CYC < 1 || WAKE_CYC >= (1 << CW)) begin
      $error("csos_top: count does not fit counter width");
    end
  end
  // ----------------------------------------
  // pin function decode
  // ----------------------------------------
  // returns {oe_n, level}; lamps only ever pull low
  function automatic logic [1:0] pin_drive(input logic [3:0] sel, input logic txen,
      input logic susp, input logic pwr_on, input logic chg, input logic txl,
      input logic rxl);
    logic [1:0] r;
    r = 2'h2;
    unique case (sel)
      csos_pkg::SEL_LINE_DRV: r = {1'b0, txen};
      csos_pkg::SEL_SLEEP_N: r = {1'b0, ~susp};
      csos_pkg::SEL_SLEEP: r = {1'b0, susp};
      csos_pkg::SEL_POWER_EN_N: r = {1'b0, ~pwr_on};
      csos_pkg::SEL_CHARGE: r = {1'b0, chg};
      csos_pkg::SEL_CHARGE_N: r = {1'b0, ~chg};
      csos_pkg::SEL_TX_LAMP: r = {~txl, 1'b0};
      csos_pkg::SEL_RX_LAMP: r = {~rxl, 1'b0};
      csos_pkg::SEL_BOTH_LAMP: r = {~(txl | rxl), 1'b0};
      default: r = 2'h2;
    endcase
    return r;
  endfunction
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [5:0] sync1;
  logic [5:0] sync2;
  // pins are asynchronous; only sync2 is read
  always_ff @(posedge i_core_clk) begin
    sync1 <= {i_dcp_short, i_ring_indicate_n_pin, i_carrier_detect_pin,
              i_dsr_pin, i_cts_pin, i_rxd_pin};
    sync2 <= sync1;
  end
  // ----------------------------------------
  // configuration load
  // ----------------------------------------
  csos_pkg::csos_load_t ld_state;
  logic [1:0] ld_idx;
  logic [15:0] pin_sel_w;
  logic [15:0] opt_w;
  logic [15:0] pwr_w;
  // factory values hold until the memory answers; reload on usb reset too
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ld_state <= csos_pkg::LD_READ;
      ld_idx <= 2'h0;
      pin_sel_w <= csos_pkg::DEF_PIN_SEL;
      opt_w <= csos_pkg::DEF_OPTIONS;
      pwr_w <= csos_pkg::DEF_MAX_POWER;
    end else if (i_usb_reset) begin
      ld_state <= csos_pkg::LD_READ;
      ld_idx <= 2'h0;
    end else begin
      unique case (ld_state)
        csos_pkg::LD_IDLE: ld_state <= csos_pkg::LD_DONE;
        csos_pkg::LD_READ: begin
          if (i_cfg_rd_valid) begin
            unique case (ld_idx)
              2'h0: pin_sel_w <= i_cfg_rd_data;
              2'h1: opt_w <= i_cfg_rd_data;
              default: pwr_w <= i_cfg_rd_data;
            endcase
            if (ld_idx == csos_pkg::CFG_WORDS - 2'h1) begin
              ld_state <= csos_pkg::LD_DONE;
            end
            ld_idx <= ld_idx + 2'h1;
          end
        end
        csos_pkg::LD_DONE: ld_state <= csos_pkg::LD_DONE;
        default: ld_state <= csos_pkg::LD_IDLE;
      endcase
    end
  end
  // read strobe is held until the word is returned
  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_usb_reset) begin
      o_cfg_rd_en <= 1'b0;
      o_cfg_rd_addr <= csos_pkg::CFG_BASE;
      o_cfg_loaded <= 1'b0;
    end else begin
      o_cfg_rd_en <= (ld_state == csos_pkg::LD_READ) && !(i_cfg_rd_valid &&
                     ld_idx == csos_pkg::CFG_WORDS - 2'h1);
      o_cfg_rd_addr <= csos_pkg::CFG_BASE + 10'(ld_idx + (i_cfg_rd_valid ? 2'h1 : 2'h0));
      o_cfg_loaded <= (ld_state == csos_pkg::LD_DONE);
    end
  end
  // descriptor fields except the fixed usb version taken from the loaded words, factory values in reset
  always_ff @(posedge i_core_clk) begin
    o_usb_version <= csos_pkg::USB_VERSION;
    o_max_power_ma <= i_rst ? csos_pkg::DEF_MAX_POWER[8:0] : pwr_w[8:0];
    o_bus_powered <= i_rst || !opt_w[csos_pkg::OPT_SELF_PWR];
    o_serial_enable <= i_rst || opt_w[csos_pkg::OPT_SERIAL];
  end
  // ----------------------------------------
  // charge port detection
  // ----------------------------------------
  logic chg_on;
  // sticky until a standard host enumerates us or usb reset
  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_usb_reset) begin
      o_suspend_request <= 1'b0;
    end else if (sync2[5]) begin
      o_suspend_request <= 1'b1;
    end else if (i_enumerated) begin
      o_suspend_request <= 1'b0;
    end
  end
  assign chg_on = o_suspend_request && i_suspended && !i_enumerated;
  // ----------------------------------------
  // activity lamps
  // ----------------------------------------
  logic [CW-1:0] tx_cnt;
  logic [CW-1:0] rx_cnt;
  // each byte restarts the one-shot so bursts read as one glow
  function automatic logic [CW-1:0] lamp_next(input logic [CW-1:0] cnt, input logic hit);
    logic [CW-1:0] r;
    r = (cnt != '0) ? cnt - 1'b1 : cnt;
    if (hit) begin
      r = CW'(LAMP_CYC);
    end
    return r;
  endfunction
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tx_cnt <= '0;
      rx_cnt <= '0;
    end else begin
      tx_cnt <= lamp_next(tx_cnt, i_uart_rx_byte);
      rx_cnt <= lamp_next(rx_cnt, i_usb_rx_byte);
    end
  end
  // ----------------------------------------
  // line driver enable
  // ----------------------------------------
  csos_pkg::csos_txen_t tx_state;
  // the uart is held off one bit so the driver is up before the start bit
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      tx_state <= csos_pkg::TX_IDLE;
      o_line_driver_enable <= 1'b0;
      o_uart_tx_go <= 1'b0;
    end else begin
      o_uart_tx_go <= 1'b0;
      unique case (tx_state)
        csos_pkg::TX_IDLE: begin
          if (i_tx_char_ready) begin
            tx_state <= csos_pkg::TX_LEAD;
            o_line_driver_enable <= 1'b1;
          end
        end
        csos_pkg::TX_LEAD: begin
          if (i_bit_tick) begin
            tx_state <= csos_pkg::TX_FRAME;
            o_uart_tx_go <= 1'b1;
          end
        end
        csos_pkg::TX_FRAME: begin
          if (i_tx_stop_bit) begin
            tx_state <= csos_pkg::TX_IDLE;
            o_line_driver_enable <= 1'b0;
          end
        end
        default: tx_state <= csos_pkg::TX_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // configurable pins
  // ----------------------------------------
  logic pwr_on;
  assign pwr_on = i_enumerated && !i_suspended;
  // pins float during reset; the select codes decide afterwards
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_status_pin_out <= 4'h0;
      o_status_pin_oe_n <= 4'hf;
    end else begin
      for (int k = 0; k < 4; k++) begin
        {o_status_pin_oe_n[k], o_status_pin_out[k]} <= pin_drive(pin_sel_w[4*k +: 4],
          o_line_driver_enable, i_suspended, pwr_on, chg_on, tx_cnt != '0,
          rx_cnt != '0);
      end
    end
  end
  // ----------------------------------------
  // uart line polarity and suspend pull-down
  // ----------------------------------------
  logic pull_low;
  assign pull_low = opt_w[csos_pkg::OPT_PULLDOWN] && i_suspended;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_uart_oe_n <= 1'b1;
      o_uart_pulldown <= 1'b0;
      o_uart_txd <= 1'b0;
      o_uart_rts <= 1'b0;
      o_uart_dtr <= 1'b0;
    end else begin
      o_uart_oe_n <= pull_low;
      o_uart_pulldown <= pull_low;
      o_uart_txd <= !pull_low && (i_txd ^ opt_w[csos_pkg::INV_TXD]);
      o_uart_rts <= !pull_low && (i_rts ^ opt_w[csos_pkg::INV_RTS]);
      o_uart_dtr <= !pull_low && (i_dtr ^ opt_w[csos_pkg::INV_DTR]);
    end
  end
  // inputs are flipped after synchronising
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rxd <= 1'b1;
      o_cts <= 1'b0;
      o_dsr <= 1'b0;
      o_carrier_detect <= 1'b0;
      o_ring_indicate <= 1'b0;
    end else begin
      o_rxd <= sync2[0] ^ opt_w[csos_pkg::INV_RXD];
      o_cts <= sync2[1] ^ opt_w[csos_pkg::INV_CTS];
      o_dsr <= sync2[2] ^ opt_w[csos_pkg::INV_DSR];
      o_carrier_detect <= sync2[3] ^ opt_w[csos_pkg::INV_DCD];
      o_ring_indicate <= ~(sync2[4] ^ opt_w[csos_pkg::INV_RI]);
    end
  end
  // ----------------------------------------
  // remote wake
  // ----------------------------------------
  logic [CW-1:0] wake_cnt;
  logic wake_arm;
  assign wake_arm = i_suspended && opt_w[csos_pkg::OPT_WAKE];
  // once ring is seen the delay runs out even if ring is released early
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !wake_arm) begin
      wake_cnt <= '0;
      o_remote_wake <= 1'b0;
    end else if (!o_remote_wake && (o_ring_indicate || wake_cnt != '0)) begin
      if (wake_cnt == CW'(WAKE_CYC - 1)) begin
        o_remote_wake <= 1'b1;
        wake_cnt <= '0;
      end else begin
        wake_cnt <= wake_cnt + 1'b1;
      end
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_charge_needs_susp: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ($past(pin_sel_w[3:0]) == csos_pkg::SEL_CHARGE && o_status_pin_out[0])
    |-> $past(i_suspended) && $past(o_suspend_request))
    else $error("charger output without suspend");
  a_charge_off_enum: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ($past(i_enumerated) && $past(pin_sel_w[7:4]) == csos_pkg::SEL_CHARGE_N)
    |-> o_status_pin_out[1] && !o_status_pin_oe_n[1])
    else $error("active-low charger asserted while enumerated");
  a_dcp_sets_req: assert property (@(posedge i_core_clk) disable iff (i_rst || i_usb_reset)
    sync2[5] |=> o_suspend_request)
    else $error("short not flagged");
  a_lamp_retrig: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_uart_rx_byte |=> tx_cnt == CW'(LAMP_CYC) ##1 tx_cnt == CW'(LAMP_CYC - 1)
      || $past(i_uart_rx_byte))
    else $error("lamp one-shot not reloaded");
  a_lamp_low_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
    ($past(pin_sel_w[7:4]) == csos_pkg::SEL_RX_LAMP)
    |-> !o_status_pin_out[1] && (o_status_pin_oe_n[1] == ($past(rx_cnt) == '0)))
    else $error("rx lamp drive wrong");
  a_sleep_level: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (!$past(i_rst) && $past(pin_sel_w[15:12]) == csos_pkg::SEL_SLEEP_N)
    |-> !o_status_pin_oe_n[3] && o_status_pin_out[3] == !$past(i_suspended))
    else $error("sleep indicator wrong");
  a_driver_lead: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_uart_tx_go |-> o_line_driver_enable && $past(o_line_driver_enable))
    else $error("start released before driver enabled");
  a_reset_float: assert property (@(posedge i_core_clk)
    i_rst |=> o_uart_oe_n && o_status_pin_oe_n == 4'hf)
    else $error("pins driven in reset");
  a_txd_invert: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !$past(i_rst) && !$past(pull_low)
    |-> o_uart_txd == ($past(i_txd) ^ $past(opt_w[csos_pkg::INV_TXD])))
    else $error("txd polarity wrong");
  a_cfg_reload: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_usb_reset |=> ld_state == csos_pkg::LD_READ && ld_idx == 2'h0 && !o_cfg_loaded)
    else $error("usb reset did not reload config");
  c_charge_on: cover property (@(posedge i_core_clk) chg_on);
  c_lamp_both: cover property (@(posedge i_core_clk) tx_cnt != '0 && rx_cnt != '0);
  c_wake: cover property (@(posedge i_core_clk) $rose(o_remote_wake));
  c_cfg_done: cover property (@(posedge i_core_clk) $rose(o_cfg_loaded));
endmodule

// file: dv/csos_cfg_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// config memory model, answers word reads
// ----------------------------------------
module csos_cfg_model (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_rd_en,
  input wire logic [9:0] i_rd_addr,
  input wire logic i_image,
  input wire logic [3:0] i_wait,
  output logic o_rd_valid,
  output logic [15:0] o_rd_data
);
  logic [3:0] wait_cnt;
  logic [15:0] word;
  logic [9:0] idx;
  // image 0 is factory content, image 1 a reprogrammed part
  assign idx = i_rd_addr - 10'h050;
  always_comb begin
    case (idx)
      10'h000: word = i_image ? 16'h5476 : 16'h3210;
      10'h001: word = i_image ? 16'h0301 : 16'h0600;
      10'h002: word = i_image ? 16'h0064 : 16'h005a;
      default: word = 16'h0000;
    endcase
  end
  // answer after i_wait idle cycles; between answers the data bus toggles
  // every cycle, so a capture one cycle late sees the inverse of the word
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= 16'h0000;
      wait_cnt <= 4'h0;
    end else if (i_rd_en && !o_rd_valid && wait_cnt == i_wait) begin
      o_rd_valid <= 1'b1;
      o_rd_data <= word;
      wait_cnt <= 4'h0;
    end else begin
      o_rd_valid <= 1'b0;
      o_rd_data <= ~o_rd_data;
      wait_cnt <= (i_rd_en && !o_rd_valid) ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// file: dv/configurable_status_pins_status_output_select_bench.sv
`timescale 1ns/1ps
module configurable_status_pins_status_output_select_bench;
  localparam int LAMP = 8;
  localparam int WAKE = 16;
  logic clk = 1'b0, rst = 1'b1, usb_rst = 1'b0, susp = 1'b0, enum_h = 1'b0;
  logic dedicated_charge_port = 1'b0, urx = 1'b0, usbrx = 1'b0, rdy = 1'b0, bt = 1'b0, stp = 1'b0;
  logic txd = 1'b1, rts = 1'b0, dtr = 1'b0, rxdp = 1'b1, ctsp = 1'b0, dsrp = 1'b0;
  logic dcdp = 1'b0, rip = 1'b1, image = 1'b0;
  logic [3:0] mem_wait = 4'h0;
  logic rd_valid, rd_en, loaded, drv_en, tx_go, u_txd, u_rts, u_dtr, u_oe_n, u_pd;
  logic rxd, cts, dsr, dcd, ring, susp_req, wake, bus_pwr, ser_en;
  logic [15:0] rd_data, usb_ver;
  logic [9:0] rd_addr;
  logic [3:0] pin_out, pin_oe_n;
  logic [8:0] max_pwr;
  int mismatches = 0;
  int compares = 0;
  int go_cnt;
  csos_top #(.LAMP_CYC(LAMP), .WAKE_CYC(WAKE), .CW(20)) dut (
    .i_core_clk(clk), .i_rst(rst), .i_usb_reset(usb_rst), .i_suspended(susp),
    .i_enumerated(enum_h), .i_dcp_short(dedicated_charge_port), .i_uart_rx_byte(urx),
    .i_usb_rx_byte(usbrx), .i_tx_char_ready(rdy), .i_bit_tick(bt),
    .i_tx_stop_bit(stp), .i_txd(txd), .i_rts(rts), .i_dtr(dtr), .i_rxd_pin(rxdp),
    .i_cts_pin(ctsp), .i_dsr_pin(dsrp), .i_carrier_detect_pin(dcdp),
    .i_ring_indicate_n_pin(rip), .i_cfg_rd_valid(rd_valid), .i_cfg_rd_data(rd_data),
    .o_cfg_rd_en(rd_en), .o_cfg_rd_addr(rd_addr), .o_cfg_loaded(loaded),
    .o_status_pin_out(pin_out), .o_status_pin_oe_n(pin_oe_n),
    .o_line_driver_enable(drv_en), .o_uart_tx_go(tx_go), .o_uart_txd(u_txd),
    .o_uart_rts(u_rts), .o_uart_dtr(u_dtr), .o_uart_oe_n(u_oe_n),
    .o_uart_pulldown(u_pd), .o_rxd(rxd), .o_cts(cts), .o_dsr(dsr),
    .o_carrier_detect(dcd), .o_ring_indicate(ring), .o_suspend_request(susp_req),
    .o_remote_wake(wake), .o_usb_version(usb_ver), .o_max_power_ma(max_pwr),
    .o_bus_powered(bus_pwr), .o_serial_enable(ser_en)
  );
  csos_cfg_model mem (
    .i_core_clk(clk), .i_rst(rst), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
    .i_image(image), .i_wait(mem_wait), .o_rd_valid(rd_valid), .o_rd_data(rd_data)
  );
  // ----------------------------------------
  // clock, helpers
  // ----------------------------------------
  initial begin
    forever #20 clk = ~clk;
  end
  // inputs move and outputs are read on falling edges, away from sampling
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, mismatches);
  endtask
  // bounded wait, a hung load shows up as a mismatch
  task automatic wait_loaded();
    int k;
    for (k = 0; k < 100 && loaded !== 1'b1; k++) wait_n(1);
    check(loaded, 1'b1);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    wait_n(1);
    s = 1'b0;
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // watchdog, far beyond the few hundred cycles the tests need
  // ----------------------------------------
  initial begin
    #(40 * 4000);
    mismatches++;
    end_of_test();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    wait_n(2);
    check(u_oe_n, 1'b1);
    check(pin_oe_n, 4'hf);
    wait_n(1);
    rst = 1'b0;
    wait_loaded();
    check(usb_ver, 16'h0200);
    check(max_pwr, 9'h05a);
    check(bus_pwr, 1'b1);
    check(ser_en, 1'b1);
    check(u_oe_n, 1'b0);
    rxdp = 1'b0;
    ctsp = 1'b1;
    dsrp = 1'b1;
    dcdp = 1'b1;
    txd = 1'b0;
    rts = 1'b1;
    dtr = 1'b1;
    wait_n(4);
    check({rxd, cts, dsr, dcd}, 4'h7);
    check({u_txd, u_rts}, 2'h1);
    check({ring, u_dtr}, 2'h1);
    done("defaults");
    // factory pin 2 is the tx lamp, retriggered before it expires
    pulse(urx);
    wait_n(2);
    check({pin_oe_n[2], pin_oe_n[1], pin_out[2]}, 3'b010);
    wait_n(3);
    pulse(urx);
    wait_n(6);
    check(pin_oe_n[2], 1'b0);
    wait_n(LAMP + 6);
    check(pin_oe_n[2], 1'b1);
    pulse(usbrx);
    wait_n(2);
    check({pin_oe_n[1], pin_oe_n[2]}, 2'b01);
    wait_n(LAMP + 6);
    check(pin_oe_n[1], 1'b1);
    done("lamps");
    // line driver on pin 0 across one character
    pulse(rdy);
    wait_n(2);
    check({drv_en, pin_out[0], pin_oe_n[0]}, 3'b110);
    go_cnt = 0;
    pulse(bt);
    repeat (3) begin
      if (tx_go === 1'b1) go_cnt++;
      wait_n(1);
    end
    check(16'(go_cnt), 16'h0001);
    check(drv_en, 1'b1);
    pulse(stp);
    wait_n(2);
    check({drv_en, pin_out[0]}, 2'b00);
    done("driver");
    susp = 1'b1;
    wait_n(3);
    check({pin_out[3], pin_oe_n[3]}, 2'b00);
    susp = 1'b0;
    wait_n(3);
    check(pin_out[3], 1'b1);
    done("sleep");
    // usb reset reloads a reprogrammed image from a slow memory
    image = 1'b1;
    mem_wait = 4'h4;
    pulse(usb_rst);
    wait_n(2);
    wait_loaded();
    check(max_pwr, 9'h064);
    check({ser_en, bus_pwr}, 2'b01);
    wait_n(3);
    check(u_txd, 1'b1);
    pulse(urx);
    wait_n(2);
    check(pin_oe_n[2], 1'b0);
    wait_n(LAMP + 6);
    pulse(usbrx);
    wait_n(2);
    check(pin_oe_n[2], 1'b0);
    done("reload");
    // charge port: shorted lines, then suspend
    dedicated_charge_port = 1'b1;
    wait_n(6);
    check(susp_req, 1'b1);
    check({pin_out[0], pin_out[1]}, 2'b01);
    susp = 1'b1;
    wait_n(3);
    check({pin_out[0], pin_out[1], pin_out[3]}, 3'b101);
    check({u_pd, u_oe_n, u_txd, u_dtr}, 4'hc);
    rip = 1'b0;
    wait_n(5);
    check(wake, 1'b0);
    wait_n(WAKE + 10);
    check(wake, 1'b1);
    rip = 1'b1;
    enum_h = 1'b1;
    wait_n(3);
    check({pin_out[0], wake}, 2'h1);
    susp = 1'b0;
    wait_n(3);
    check({pin_out[0], pin_out[1], wake, u_pd}, 4'h4);
    done("charger");
    end_of_test();
  end
endmodule
